// [rtl/idc_pkg.sv]
// Constants, types and helpers shared by the clock-mode controller
package idc_pkg;

	// Register byte addresses on APB
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

	// Control register field positions
	localparam int CTRL_TWO_CLK_BIT = 0;
	localparam int CTRL_PRESC_LSB   = 1;
	localparam int CTRL_RATIO_LSB   = 3;
	localparam int CTRL_PSYNC_BIT   = 5;
	localparam int CTRL_W           = 6;

	// Status register field positions
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_LOCK_BIT = 3;
	localparam int STAT_STRAP_BIT = 4;

	// Interrupt status / mask bit positions
	localparam int IRQ_LOCK_GAIN = 0;
	localparam int IRQ_LOCK_LOSS = 1;
	localparam int IRQ_PHASE     = 2;
	localparam int IRQ_W         = 3;

	// Values after reset
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam logic [IRQ_W-1:0]  MASK_RESET = 3'h0;

	// Counts of periods and cycles
	localparam logic [2:0] LOCK_MATCHES = 3'h4;  // Matching reference periods to lock
	localparam logic [7:0] PERIOD_MAX   = 8'hFF; // Reference silence that drops lock

	// Clock mode, one-hot
	typedef enum logic [2:0] {
		MODE_EXT  = 3'b001,
		MODE_PLL  = 3'b010,
		MODE_DUAL = 3'b100
	} idc_mode_t;

	// Lock tracker state, one-hot
	typedef enum logic [2:0] {
		LK_OFF = 3'b001,
		LK_ACQ = 3'b010,
		LK_ON  = 3'b100
	} idc_lock_t;

	// Control fields as software writes them
	typedef struct packed {
		logic       phase_sync_en;
		logic [1:0] ratio;
		logic [1:0] prescale;
		logic       two_clock_sel;
	} idc_cfg_t;

	// Two to the power of a small exponent
	function automatic logic [7:0] idc_pow2(input logic [2:0] e);
		idc_pow2 = 8'h01 << e;
	endfunction

endpackage

// [rtl/idc_clk_div.sv]
// Prescaler and sample-rate divider chain
`timescale 1ns/1ps
module idc_clk_div #(
	parameter int STAGES = 4
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// Control
	input  wire logic              pll_mode,
	input  wire logic [1:0]        prescale,
	input  wire logic              ext_tick,
	input  wire logic              restart,
	// Divided timing
	output logic                   sample_tick,
	output logic [STAGES-1:0]      stage_tick,
	output logic [STAGES-1:0]      div_q
);

	logic [2:0] pre_cnt;
	logic [2:0] pre_mask;

	// Mask of 0, 1, 3 or 7 gives divide by 1, 2, 4 or 8
	assign pre_mask = 3'(idc_pkg::idc_pow2({1'b0, prescale}) - 8'h01);

	// Oscillator is mclk in multiplier mode, sample pin edges otherwise
	assign sample_tick = pll_mode ? ((pre_cnt & pre_mask) == pre_mask) : ext_tick;

	// Prescale counter free-runs on mclk in multiplier mode, held at zero otherwise
	always_ff @(posedge mclk) begin
		if (reset || !pll_mode) begin
			pre_cnt <= 3'h0;
		end else begin
			pre_cnt <= pre_cnt + 3'h1;
		end
	end

	// Ripple-free binary chain; bit k runs at sample over 2^(k+1)
	always_ff @(posedge mclk) begin
		if (reset || restart) begin
			div_q <= '0;
		end else if (sample_tick) begin
			div_q <= div_q + STAGES'(1);
		end
	end

	// One pulse per period of each divided clock
	for (genvar n = 0; n < STAGES; n++) begin : g_tick
		assign stage_tick[n] = sample_tick & (&div_q[n:0]);
	end

endmodule // idc_clk_div

// [rtl/idc_clock_ctrl.sv]
// Clock-mode controller: mode decode, dividers, lock tracker, APB registers
`timescale 1ns/1ps
module idc_clock_ctrl (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Device pins
	input  wire logic        multiplier_supply_strap,
	input  wire logic        data_rate_clock_in,
	input  wire logic        sample_rate_clock_in,
	input  wire logic        phase_strobe_in,
	output logic             lock_or_data_clock_out,
	// Internal clock enables
	output logic             sample_clk_en,
	output logic             data_clk_en,
	output logic [3:0]       fir_stage_en,
	// Interrupt
	output logic             irq
);

	idc_pkg::idc_cfg_t              cfg;
	idc_pkg::idc_mode_t             mode;
	idc_pkg::idc_lock_t             lock_state;
	idc_pkg::idc_lock_t             next_lock_state;
	logic                           strap_q;
	logic                           sr_prev;
	logic                           dr_prev;
	logic                           ps_prev;
	logic                           sr_rise;
	logic                           dr_rise;
	logic                           ps_rise;
	logic                           restart;
	logic                           sample_tick;
	logic [3:0]                     stage_tick;
	logic [3:0]                     div_q;
	logic [3:0]                     cfg_prev;
	logic                           cfg_chg;
	logic [7:0]                     per_cnt;
	logic [7:0]                     per_expect;
	logic                           per_match;
	logic [2:0]                     match_cnt;
	logic [idc_pkg::IRQ_W-1:0]      irq_stat;
	logic [idc_pkg::IRQ_W-1:0]      irq_mask;
	logic [idc_pkg::IRQ_W-1:0]      irq_event;
	logic [idc_pkg::IRQ_W-1:0]      irq_clr;
	logic                           acc_wr;
	logic                           setup;
	logic                           addr_hit;
	logic [31:0]                    rd_val;

	// Pins are synchronous to mclk; edges found against last sample
	always_ff @(posedge mclk) begin
		if (reset) begin
			strap_q <= 1'b0;
			sr_prev <= 1'b0;
			dr_prev <= 1'b0;
			ps_prev <= 1'b0;
		end else begin
			strap_q <= multiplier_supply_strap;
			sr_prev <= sample_rate_clock_in;
			dr_prev <= data_rate_clock_in;
			ps_prev <= phase_strobe_in;
		end
	end

	assign sr_rise = sample_rate_clock_in & ~sr_prev;
	assign dr_rise = data_rate_clock_in & ~dr_prev;
	assign ps_rise = phase_strobe_in & ~ps_prev;

	// Strap outranks the two-clock bit entirely
	always_comb begin
		if (strap_q) begin
			mode = idc_pkg::MODE_PLL;
		end else if (cfg.two_clock_sel) begin
			mode = idc_pkg::MODE_DUAL;
		end else begin
			mode = idc_pkg::MODE_EXT;
		end
	end

	// Strobe only aligns dividers when enabled and clocked externally
	assign restart = ps_rise & cfg.phase_sync_en & (mode == idc_pkg::MODE_EXT);

	// Sample pin is ignored in multiplier mode; prescaler runs on mclk
	idc_clk_div #(
		.STAGES(4)
	) u_div (
		.mclk        (mclk),
		.reset       (reset),
		.pll_mode    (mode == idc_pkg::MODE_PLL),
		.prescale    (cfg.prescale),
		.ext_tick    (sr_rise),
		.restart     (restart),
		.sample_tick (sample_tick),
		.stage_tick  (stage_tick),
		.div_q       (div_q)
	);

	// Selection change seen one cycle after the write
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_prev <= 4'h0;
		end else begin
			cfg_prev <= {cfg.ratio, cfg.prescale};
		end
	end

	assign cfg_chg = ({cfg.ratio, cfg.prescale} != cfg_prev);

	// Feedback period in mclk cycles is prescale times ratio
	assign per_expect = idc_pkg::idc_pow2(3'({1'b0, cfg.prescale} + {1'b0, cfg.ratio}) + 3'h1);
	assign per_match  = (per_cnt == per_expect - 8'h01);

	// Reference period measure, saturating so silence is visible
	always_ff @(posedge mclk) begin
		if (reset || dr_rise) begin
			per_cnt <= 8'h00;
		end else if (per_cnt != idc_pkg::PERIOD_MAX) begin
			per_cnt <= per_cnt + 8'h01;
		end
	end

	// Lock model: reference must match feedback for several periods
	always_comb begin
		next_lock_state = lock_state;
		unique case (lock_state)
			idc_pkg::LK_OFF: begin
				next_lock_state = idc_pkg::LK_ACQ;
			end
			idc_pkg::LK_ACQ: begin
				if (dr_rise && per_match && match_cnt == idc_pkg::LOCK_MATCHES - 3'h1) begin
					next_lock_state = idc_pkg::LK_ON;
				end
			end
			idc_pkg::LK_ON: begin
				if ((dr_rise && !per_match) || per_cnt == idc_pkg::PERIOD_MAX) begin
					next_lock_state = idc_pkg::LK_ACQ;
				end
			end
		endcase
		if (mode != idc_pkg::MODE_PLL) begin
			next_lock_state = idc_pkg::LK_OFF;
		end else if (cfg_chg) begin
			next_lock_state = idc_pkg::LK_ACQ;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			lock_state <= idc_pkg::LK_OFF;
		end else begin
			lock_state <= next_lock_state;
		end
	end

	// Matched periods; any miss or reselect starts over
	always_ff @(posedge mclk) begin
		if (reset || cfg_chg || lock_state != idc_pkg::LK_ACQ) begin
			match_cnt <= 3'h0;
		end else if (dr_rise) begin
			match_cnt <= per_match ? match_cnt + 3'h1 : 3'h0;
		end
	end

	// Multi-use pin: lock, divided clock, or held low
	always_ff @(posedge mclk) begin
		if (reset) begin
			lock_or_data_clock_out <= 1'b0;
		end else begin
			unique case (mode)
				idc_pkg::MODE_PLL:  lock_or_data_clock_out <= (lock_state == idc_pkg::LK_ON);
				idc_pkg::MODE_EXT:  lock_or_data_clock_out <= div_q[cfg.ratio];
				idc_pkg::MODE_DUAL: lock_or_data_clock_out <= 1'b0;
			endcase
		end
	end

	// Clock enables; dual mode takes data timing from the reference pin
	always_ff @(posedge mclk) begin
		if (reset) begin
			sample_clk_en <= 1'b0;
			data_clk_en   <= 1'b0;
		end else begin
			sample_clk_en <= (mode == idc_pkg::MODE_DUAL) ? sr_rise : sample_tick;
			data_clk_en   <= (mode == idc_pkg::MODE_DUAL) ? dr_rise : stage_tick[cfg.ratio];
		end
	end

	// Only the stages the ratio needs are clocked, saving power
	for (genvar n = 0; n < 4; n++) begin : g_stage
		always_ff @(posedge mclk) begin
			if (reset) begin
				fir_stage_en[n] <= 1'b0;
			end else begin
				fir_stage_en[n] <= stage_tick[n] & (2'(n) <= cfg.ratio);
			end
		end
	end

	// Interrupt events
	assign irq_event[idc_pkg::IRQ_LOCK_GAIN] = (next_lock_state == idc_pkg::LK_ON) && (lock_state != idc_pkg::LK_ON);
	assign irq_event[idc_pkg::IRQ_LOCK_LOSS] = (lock_state == idc_pkg::LK_ON) && (next_lock_state != idc_pkg::LK_ON);
	assign irq_event[idc_pkg::IRQ_PHASE]     = restart;

	// APB decode; access completes in the cycle after setup
	assign setup    = psel & ~penable & ~pready;
	assign acc_wr   = psel & penable & pready & pwrite & ~pslverr;
	assign addr_hit = (paddr == idc_pkg::ADDR_CTRL) || (paddr == idc_pkg::ADDR_STATUS)
		|| (paddr == idc_pkg::ADDR_IRQ_STAT) || (paddr == idc_pkg::ADDR_IRQ_MASK);
	assign irq_clr  = (acc_wr && paddr == idc_pkg::ADDR_IRQ_STAT) ? pwdata[idc_pkg::IRQ_W-1:0] : '0;

	// Read mux; unused bits read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (paddr)
			idc_pkg::ADDR_CTRL:     rd_val[idc_pkg::CTRL_W-1:0] = cfg;
			idc_pkg::ADDR_STATUS: begin
				rd_val[idc_pkg::STAT_MODE_LSB +: 3] = mode;
				rd_val[idc_pkg::STAT_LOCK_BIT]      = (lock_state == idc_pkg::LK_ON);
				rd_val[idc_pkg::STAT_STRAP_BIT]     = strap_q;
			end
			idc_pkg::ADDR_IRQ_STAT: rd_val[idc_pkg::IRQ_W-1:0] = irq_stat;
			idc_pkg::ADDR_IRQ_MASK: rd_val[idc_pkg::IRQ_W-1:0] = irq_mask;
			default:                rd_val = 32'h0000_0000;
		endcase
	end

	// Answer registered at setup so bus outputs come from flops
	always_ff @(posedge mclk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup) begin
			pready  <= 1'b1;
			pslverr <= ~addr_hit;
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	// Writable control and mask
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg      <= idc_pkg::CTRL_RESET;
			irq_mask <= idc_pkg::MASK_RESET;
		end else if (acc_wr && paddr == idc_pkg::ADDR_CTRL) begin
			cfg <= pwdata[idc_pkg::CTRL_W-1:0];
		end else if (acc_wr && paddr == idc_pkg::ADDR_IRQ_MASK) begin
			irq_mask <= pwdata[idc_pkg::IRQ_W-1:0];
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge mclk) begin
		if (reset) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_event;
			irq      <= |(((irq_stat & ~irq_clr) | irq_event) & irq_mask);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_strap_forces_pll: assert property (strap_q |-> mode == idc_pkg::MODE_PLL)
		else $error("strap high but mode not multiplier");
	a_presc_div8: assert property ((mode == idc_pkg::MODE_PLL && cfg.prescale == 2'b11 && sample_tick)
		##1 (mode == idc_pkg::MODE_PLL && cfg.prescale == 2'b11 && !sample_tick)[*7] |=> sample_tick)
		else $error("prescale divide by 8 period wrong");
	a_chain_counts: assert property (sample_tick && !restart |=> div_q == $past(div_q) + 4'h1)
		else $error("divider chain did not advance");
	a_data_tick_ext: assert property (mode == idc_pkg::MODE_EXT && stage_tick[cfg.ratio] |=> data_clk_en)
		else $error("data clock enable missed");
	a_lock_on_pin: assert property (mode == idc_pkg::MODE_PLL && lock_state == idc_pkg::LK_ON
		|=> lock_or_data_clock_out)
		else $error("lock not shown on pin");
	a_ext_half_rate: assert property ((mode == idc_pkg::MODE_EXT && cfg.ratio == 2'b00 && sample_tick && !restart)
		##1 (mode == idc_pkg::MODE_EXT && cfg.ratio == 2'b00) |=> lock_or_data_clock_out != $past(lock_or_data_clock_out))
		else $error("divided clock did not toggle");
	a_dual_data_ref: assert property (mode == idc_pkg::MODE_DUAL && dr_rise |=> data_clk_en)
		else $error("dual mode data timing not from reference");
	a_dual_pin_low: assert property (mode == idc_pkg::MODE_DUAL |=> !lock_or_data_clock_out)
		else $error("pin not low in dual mode");
	a_stage_gated: assert property (fir_stage_en[3] |-> $past(cfg.ratio) == 2'b11)
		else $error("unused filter stage clocked");
	a_ext_no_lock: assert property (mode == idc_pkg::MODE_EXT |=> lock_state == idc_pkg::LK_OFF)
		else $error("loop active outside multiplier mode");
	a_strobe_restart: assert property (restart |=> div_q == 4'h0 && irq_stat[idc_pkg::IRQ_PHASE])
		else $error("strobe did not restart dividers");
	a_cfg_drops_lock: assert property (cfg_chg && mode == idc_pkg::MODE_PLL |=> lock_state == idc_pkg::LK_ACQ)
		else $error("lock held across selection change");

	c_lock_reached: cover property (lock_state == idc_pkg::LK_ACQ ##1 lock_state == idc_pkg::LK_ON);
	c_dual_data: cover property (mode == idc_pkg::MODE_DUAL && data_clk_en);
	c_phase_sync: cover property (restart);
	c_irq_raised: cover property (!irq ##1 irq);

endmodule // idc_clock_ctrl

// [dv/idc_clk_src.sv]
// Model of the external clock source at the device pins
`timescale 1ns/1ps
module idc_clk_src (
	// Clock
	input  wire logic       mclk,
	// Settings from the bench
	input  wire logic       ref_on,
	input  wire logic       smp_on,
	input  wire logic [7:0] ref_period,
	input  wire logic [7:0] smp_period,
	// Clock pins
	output logic            ref_clk = 1'b0,
	output logic            smp_clk = 1'b0
);
	logic [7:0] ref_cnt = 8'h00;
	logic [7:0] smp_cnt = 8'h00;

	// Data-rate reference; stands low while off so no stray edge is seen
	always_ff @(posedge mclk) begin
		ref_cnt <= (!ref_on || ref_cnt >= ref_period - 8'h01) ? 8'h00 : ref_cnt + 8'h01;
		ref_clk <= ref_on && (ref_cnt < (ref_period >> 1));
	end

	// Sample-rate clock, same shape; a period of two keeps a low between rises
	always_ff @(posedge mclk) begin
		smp_cnt <= (!smp_on || smp_cnt >= smp_period - 8'h01) ? 8'h00 : smp_cnt + 8'h01;
		smp_clk <= smp_on && (smp_cnt < (smp_period >> 1));
	end
endmodule // idc_clk_src

// [dv/interp_dac_clock_modes_tb.sv]
// Self-checking bench for the clock-mode controller
`timescale 1ns/1ps
module interp_dac_clock_modes_tb;
	logic        mclk    = 1'b0;
	logic        reset   = 1'b1;
	logic [7:0]  paddr   = 8'h00;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic        strap   = 1'b0;
	logic        strobe  = 1'b0;
	logic        ref_on  = 1'b0;
	logic        smp_on  = 1'b1;
	logic [7:0]  ref_per = 8'h08;
	logic [7:0]  smp_per = 8'h02;
	logic [31:0] prdata, q;
	logic        pready, pslverr, e, hi;
	logic        ref_clk, smp_clk, out_pin, smp_en, dat_en, irq;
	logic [3:0]  fir_en, f;
	int          fails = 0;
	int          check_count = 0;
	int          s, d, r, n;

	// 25 MHz clock
	always #20 mclk = ~mclk;

	idc_clock_ctrl dut_u (.mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.multiplier_supply_strap(strap), .data_rate_clock_in(ref_clk), .sample_rate_clock_in(smp_clk),
		.phase_strobe_in(strobe), .lock_or_data_clock_out(out_pin), .sample_clk_en(smp_en),
		.data_clk_en(dat_en), .fir_stage_en(fir_en), .irq(irq));

	idc_clk_src src_u (.mclk(mclk), .ref_on(ref_on), .smp_on(smp_on), .ref_period(ref_per),
		.smp_period(smp_per), .ref_clk(ref_clk), .smp_clk(smp_clk));

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; an idle edge after it keeps drivers from clashing
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	// Count enables and pin rises, and gather which stages pulsed, over c cycles
	task automatic watch(input int c);
		logic o;
		s = 0;
		d = 0;
		r = 0;
		f = 4'h0;
		hi = 1'b0;
		o = out_pin;
		repeat (c) begin
			@(posedge mclk);
			s += (smp_en === 1'b1);
			d += (dat_en === 1'b1);
			r += (out_pin === 1'b1 && o === 1'b0);
			f |= fir_en;
			hi |= (out_pin !== 1'b0);
			o = out_pin;
		end
	endtask

	// Raise the strobe and time the next pin rise; early cycles skipped
	task automatic strobe_rise(output int dly);
		logic o;
		dly = 4;
		strobe <= 1'b1;
		repeat (4) @(posedge mclk);
		o = out_pin;
		while (dly < 100) begin
			@(posedge mclk);
			dly++;
			if (out_pin === 1'b1 && o === 1'b0)
				break;
			o = out_pin;
		end
		strobe <= 1'b0;
	endtask

	task automatic t_regs;
		apb(1'b0, idc_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, q);
		apb(1'b0, idc_pkg::ADDR_STATUS, 32'h0);
		chk("status reset", 32'h01, q);
		apb(1'b0, idc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("irq stat reset", 32'h0, q);
		apb(1'b0, idc_pkg::ADDR_IRQ_MASK, 32'h0);
		chk("irq mask reset", 32'h0, q);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, idc_pkg::ADDR_STATUS, 32'h1F);
		apb(1'b0, idc_pkg::ADDR_STATUS, 32'h0);
		chk("status read only", 32'h01, q);
		apb(1'b1, idc_pkg::ADDR_CTRL, 32'h3F);
		apb(1'b0, idc_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl readback", 32'h3F, q);
		$display("registers done");
	endtask

	task automatic t_ext;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, idc_pkg::ADDR_CTRL, 32'(i << idc_pkg::CTRL_RATIO_LSB));
			watch(64);
			watch(16 << i);
			chk("ext pin rises", 32'd4, 32'(r));
			chk("ext sample ticks", 32'(8 << i), 32'(s));
			chk("ext data ticks", 32'd4, 32'(d));
			chk("ext fir stages", 32'((2 << i) - 1), {28'h0, f});
		end
		$display("external mode done");
	endtask

	task automatic t_dual;
		ref_on <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, idc_pkg::ADDR_CTRL, 32'((i << idc_pkg::CTRL_RATIO_LSB) | 1));
			watch(4);
			watch(64);
			chk("dual pin", 32'h0, {31'h0, hi});
			chk("dual data ticks", 32'd8, 32'(d));
			chk("dual sample ticks", 32'd32, 32'(s));
		end
		apb(1'b0, idc_pkg::ADDR_STATUS, 32'h0);
		chk("dual status", 32'h04, q);
		$display("dual mode done");
	endtask

	task automatic t_pll;
		strap <= 1'b1;
		smp_on <= 1'b0;
		apb(1'b1, idc_pkg::ADDR_IRQ_MASK, 32'h1);
		for (int p = 0; p < 4; p++) begin
			ref_per <= 8'(2 << p);
			apb(1'b1, idc_pkg::ADDR_CTRL, 32'((p << idc_pkg::CTRL_PRESC_LSB) | 1));
			watch(300);
			chk("pll lock rise", 32'd1, 32'(r));
			watch(64);
			chk("pll sample ticks", 32'(64 >> p), 32'(s));
			chk("pll data ticks", 32'(32 >> p), 32'(d));
		end
		chk("irq on lock", 32'h1, {31'h0, irq});
		apb(1'b0, idc_pkg::ADDR_STATUS, 32'h0);
		chk("pll status", 32'h1A, q);
		apb(1'b0, idc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("irq events", 32'h3, q);
		apb(1'b1, idc_pkg::ADDR_IRQ_STAT, 32'h3);
		apb(1'b0, idc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("irq cleared", 32'h0, q);
		chk("irq low", 32'h0, {31'h0, irq});
		// Ratio change must drop lock at once; relock at the new ratio
		ref_per <= 8'h20;
		apb(1'b1, idc_pkg::ADDR_CTRL, 32'h0F);
		watch(3);
		chk("lock drop", 32'h0, {31'h0, out_pin});
		watch(300);
		chk("relock ratio", 32'd1, 32'(r));
		chk("irq on relock", 32'h1, {31'h0, irq});
		apb(1'b1, idc_pkg::ADDR_IRQ_MASK, 32'h0);
		watch(2);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("multiplier mode done");
	endtask

	task automatic t_phase;
		int d1;
		strap <= 1'b0;
		smp_on <= 1'b1;
		ref_on <= 1'b0;
		apb(1'b1, idc_pkg::ADDR_CTRL, 32'h38);
		apb(1'b1, idc_pkg::ADDR_IRQ_STAT, 32'h7);
		watch(40);
		strobe_rise(d1);
		watch(10 + d1 % 2);
		strobe_rise(n);
		chk("restart phase", 32'(d1), 32'(n));
		apb(1'b0, idc_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("restart event", 32'h4, q & 32'h4);
		$display("phase strobe done");
	endtask

	// Verdict and end of run
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_regs;
		t_ext;
		t_dual;
		t_pll;
		t_phase;
		conclude;
	end

	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		#(40 * 20000);
		fails++;
		$display("[FAIL] watchdog expected finish seen hang");
		conclude;
	end
endmodule // interp_dac_clock_modes_tb
